// File: core/wsrg_top.sv
// Wake source status and reset source gate with a classic Wishbone slave
`timescale 1ns/1ps
module wsrg_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic port_d_wake_flag,
  input wire logic port_c_wake_flag,
  input wire logic port_b_wake_flag,
  input wire logic port_a_wake_flag,
  input wire logic watchdog_wake_flag,
  input wire logic low_voltage_wake_flag,
  input wire logic pin_reset_event,
  input wire logic cpu_request_reset_event,
  input wire logic software_reset_event,
  input wire logic watchdog_reset_event,
  input wire logic main_clock_fail_event,
  input wire logic ext_osc_fail_event,
  input wire logic low_voltage_reset_event,
  output logic [15:0] wake_source_status,
  output logic [6:0] reset_forward,
  output logic reset_request,
  output logic irq
);

  // ----------------------------------------------------------------
  // Wake status
  // ----------------------------------------------------------------

  wsrg_wake_view u_wake (
    .clk(clk),
    .sys_rst(sys_rst),
    .port_d_wake_flag(port_d_wake_flag),
    .port_c_wake_flag(port_c_wake_flag),
    .port_b_wake_flag(port_b_wake_flag),
    .port_a_wake_flag(port_a_wake_flag),
    .watchdog_wake_flag(watchdog_wake_flag),
    .low_voltage_wake_flag(low_voltage_wake_flag),
    .wake_source_status(wake_source_status)
  );

  // ----------------------------------------------------------------
  // Reset source gate
  // ----------------------------------------------------------------

  logic [6:0] reset_source_enable;
  wire [6:0] reset_events;

  // Event vector in the same layout as the enable register
  assign reset_events =
    (7'(pin_reset_event) << wsrg_pkg::RST_PIN_BIT) |
    (7'(cpu_request_reset_event) << wsrg_pkg::RST_CPU_BIT) |
    (7'(software_reset_event) << wsrg_pkg::RST_SOFTWARE_BIT) |
    (7'(watchdog_reset_event) << wsrg_pkg::RST_WATCHDOG_BIT) |
    (7'(main_clock_fail_event) << wsrg_pkg::RST_MAIN_CLOCK_BIT) |
    (7'(ext_osc_fail_event) << wsrg_pkg::RST_EXT_OSC_BIT) |
    (7'(low_voltage_reset_event) << wsrg_pkg::RST_LOW_VOLTAGE_BIT);

  wsrg_reset_gate u_gate (
    .clk(clk),
    .sys_rst(sys_rst),
    .reset_events(reset_events),
    .reset_source_enable(reset_source_enable),
    .reset_forward(reset_forward),
    .reset_request(reset_request)
  );

  // ----------------------------------------------------------------
  // Wishbone slave decode
  // ----------------------------------------------------------------

  wsrg_pkg::wsrg_bus_state_t state;
  wsrg_pkg::wsrg_bus_state_t next_state;

  wire req;
  wire fire;
  wire wr_fire;
  wire rd_fire;
  wire sel_wake;
  wire sel_rse;
  wire sel_irq_status;
  wire sel_irq_mask;
  wire [31:0] rd_data;

  // Writes and read side effects land on the edge the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign fire = req & wb_ack_o;
  assign wr_fire = fire & wb_we_i;
  assign rd_fire = fire & ~wb_we_i;
  assign sel_wake = (wb_adr_i == wsrg_pkg::WAKE_STATUS_ADDR);
  assign sel_rse = (wb_adr_i == wsrg_pkg::RSE_ADDR);
  assign sel_irq_status = (wb_adr_i == wsrg_pkg::IRQ_STATUS_ADDR);
  assign sel_irq_mask = (wb_adr_i == wsrg_pkg::IRQ_MASK_ADDR);
  assign next_state = (state == wsrg_pkg::WSRG_IDLE && req) ?
                      wsrg_pkg::WSRG_ACK : wsrg_pkg::WSRG_IDLE;

  // Interrupt registers, declared here for the read mux
  logic [15:0] irq_status;
  logic [15:0] irq_mask;

  // Read mux; unmapped addresses still ack and read zero
  assign rd_data = sel_wake ? {16'h0000, wake_source_status} :
                   sel_rse ? {25'h000_0000, reset_source_enable} :
                   sel_irq_status ? {16'h0000, irq_status} :
                   sel_irq_mask ? {16'h0000, irq_mask} :
                   32'h0000_0000;

  // Ack for one cycle, then idle at least one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= wsrg_pkg::WSRG_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (state)
        wsrg_pkg::WSRG_IDLE: begin
          state <= next_state;
          wb_ack_o <= req;
        end
        wsrg_pkg::WSRG_ACK: begin
          state <= wsrg_pkg::WSRG_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          state <= wsrg_pkg::WSRG_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // Read data is captured with the ack and held while it stands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (state == wsrg_pkg::WSRG_IDLE && req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Reset source enable register
  // ----------------------------------------------------------------

  // Byte lane 0 only; bit 7 reserved and reads as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_source_enable <= wsrg_pkg::RSE_RESET;
    end else if (wr_fire && sel_rse && wb_sel_i[0]) begin
      reset_source_enable <= wb_dat_i[6:0];
    end
  end

  // Writes to the wake status address fall through with no effect

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  logic [15:0] wake_prev;
  logic request_prev;
  wire [15:0] irq_set;
  wire [15:0] irq_clear;
  wire [15:0] mask_wdata;
  wire [15:0] mask_lanes;

  // Rising edges of wake bits and of the forwarded request are the events
  assign irq_set = (wake_source_status & ~wake_prev) |
                   (16'(reset_request & ~request_prev) << wsrg_pkg::IRQ_RESET_BIT);
  assign irq_clear = (rd_fire && sel_irq_status) ? irq_status : 16'h0000;
  assign mask_lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mask_wdata = (wb_dat_i[15:0] & mask_lanes) | (irq_mask & ~mask_lanes);

  // Edge history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_prev <= wsrg_pkg::WAKE_RESET;
      request_prev <= 1'b0;
    end else begin
      wake_prev <= wake_source_status;
      request_prev <= reset_request;
    end
  end

  // Read clears the status held at ack, one cycle after capture; a same-cycle set still wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= wsrg_pkg::IRQ_STATUS_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
    end
  end

  // Mask uses byte lanes 0 and 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask <= wsrg_pkg::IRQ_MASK_RESET;
    end else if (wr_fire && sel_irq_mask) begin
      irq_mask <= mask_wdata & wsrg_pkg::IRQ_USED_MASK;
    end
  end

  // Level output, one cycle behind the status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Expected wake layout from the raw flags
  wire [15:0] wake_expect;
  assign wake_expect = {4'h0, port_d_wake_flag, port_c_wake_flag,
                        port_b_wake_flag, port_a_wake_flag, 6'h00,
                        watchdog_wake_flag, low_voltage_wake_flag};

  sequence s_rse_write;
    wr_fire && sel_rse && wb_sel_i[0];
  endsequence

  sequence s_wake_read_issue;
    state == wsrg_pkg::WSRG_IDLE && req && !wb_we_i && sel_wake;
  endsequence

  sequence s_wake_write;
    wr_fire && sel_wake;
  endsequence

  property p_wake_layout;
    !$past(sys_rst) |-> wake_source_status == $past(wake_expect);
  endproperty
  a_wake_layout: assert property (p_wake_layout)
    else $error("wake status layout mismatch");

  property p_wake_follows;
    $rose(port_a_wake_flag) |=> wake_source_status[8] ##1
      (wake_source_status[8] == $past(port_a_wake_flag));
  endproperty
  a_wake_follows: assert property (p_wake_follows)
    else $error("port A wake bit does not follow its flag");

  property p_wake_holds;
    wake_source_status[9] && port_b_wake_flag |=> wake_source_status[9];
  endproperty
  a_wake_holds: assert property (p_wake_holds)
    else $error("port B wake bit cleared while flag set");

  property p_lowvolt_clears;
    $fell(low_voltage_wake_flag) |=> !wake_source_status[0];
  endproperty
  a_lowvolt_clears: assert property (p_lowvolt_clears)
    else $error("low-voltage wake bit did not clear");

  property p_forward;
    reset_forward == $past(reset_events & reset_source_enable);
  endproperty
  a_forward: assert property (p_forward)
    else $error("forwarded reset lines wrong");

  property p_block;
    (reset_events & reset_source_enable) == 7'h00 |=> !reset_request && reset_forward == 7'h00;
  endproperty
  a_block: assert property (p_block)
    else $error("masked reset event leaked");

  property p_rse_write;
    s_rse_write |=> reset_source_enable == $past(wb_dat_i[6:0]) ##1 !wb_ack_o;
  endproperty
  a_rse_write: assert property (p_rse_write)
    else $error("enable register write not taken");

  property p_pin_bit;
    pin_reset_event && reset_source_enable[6] |=> reset_forward[6] && reset_request;
  endproperty
  a_pin_bit: assert property (p_pin_bit)
    else $error("pin reset enable not at bit 6");

  property p_wake_read;
    s_wake_read_issue |=> wb_ack_o && wb_dat_o[31:12] == 20'h0_0000 && wb_dat_o[7:2] == 6'h00;
  endproperty
  a_wake_read: assert property (p_wake_read)
    else $error("wake status unused bits not zero");

  property p_wake_write;
    s_wake_write |=> wake_source_status == $past(wake_expect);
  endproperty
  a_wake_write: assert property (p_wake_write)
    else $error("write disturbed wake status");

  property p_request_or;
    reset_request == $past(|(reset_events & reset_source_enable));
  endproperty
  a_request_or: assert property (p_request_or)
    else $error("reset request not OR of gated events");

  // Bus and interrupt housekeeping; a stuck ack would hang the master
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_rse_keep;
    !(wr_fire && sel_rse && wb_sel_i[0]) |=> $stable(reset_source_enable);
  endproperty
  a_rse_keep: assert property (p_rse_keep)
    else $error("enable register changed without a write");

  property p_wake_holds_d;
    wake_source_status[11] && port_d_wake_flag |=> wake_source_status[11];
  endproperty
  a_wake_holds_d: assert property (p_wake_holds_d)
    else $error("port D wake bit cleared while flag set");

  property p_irq_level;
    !$past(sys_rst) |-> irq == $past(|(irq_status & irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output does not follow masked status");

endmodule

// File: core/wsrg_pkg.sv
// Package: addresses, field positions and reset values of the wake/reset gate
package wsrg_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] WAKE_STATUS_ADDR = 32'h4000_0014;
  localparam logic [31:0] RSE_ADDR = 32'h4000_0018;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4000_0100;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_0104;

  // ----------------------------------------------------------------
  // Wake status field positions
  // ----------------------------------------------------------------
  localparam int WAKE_PORT_D_BIT = 11;
  localparam int WAKE_PORT_C_BIT = 10;
  localparam int WAKE_PORT_B_BIT = 9;
  localparam int WAKE_PORT_A_BIT = 8;
  localparam int WAKE_WATCHDOG_BIT = 1;
  localparam int WAKE_LOW_VOLTAGE_BIT = 0;
  localparam int WAKE_WIDTH = 16;
  localparam logic [15:0] WAKE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Reset source enable field positions
  // ----------------------------------------------------------------
  localparam int RST_PIN_BIT = 6;
  localparam int RST_CPU_BIT = 5;
  localparam int RST_SOFTWARE_BIT = 4;
  localparam int RST_WATCHDOG_BIT = 3;
  localparam int RST_MAIN_CLOCK_BIT = 2;
  localparam int RST_EXT_OSC_BIT = 1;
  localparam int RST_LOW_VOLTAGE_BIT = 0;
  localparam int RST_SOURCES = 7;
  localparam logic [6:0] RSE_RESET = 7'h49;

  // ----------------------------------------------------------------
  // Interrupt status layout: wake bits plus forwarded reset
  // ----------------------------------------------------------------
  localparam int IRQ_RESET_BIT = 15;
  localparam logic [15:0] IRQ_USED_MASK = 16'h8F03;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

  // Bus slave states
  typedef enum logic {WSRG_IDLE, WSRG_ACK} wsrg_bus_state_t;

endpackage

// File: core/wsrg_wake_view.sv
// Wake status view: places the peripheral wake flags into the status layout
`timescale 1ns/1ps
module wsrg_wake_view (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic port_d_wake_flag,
  input wire logic port_c_wake_flag,
  input wire logic port_b_wake_flag,
  input wire logic port_a_wake_flag,
  input wire logic watchdog_wake_flag,
  input wire logic low_voltage_wake_flag,
  output logic [15:0] wake_source_status
);

  // One register stage only: each bit mirrors the source flag one clock later
  wire [15:0] next_wake_status;
  assign next_wake_status =
    (16'(port_d_wake_flag) << wsrg_pkg::WAKE_PORT_D_BIT) |
    (16'(port_c_wake_flag) << wsrg_pkg::WAKE_PORT_C_BIT) |
    (16'(port_b_wake_flag) << wsrg_pkg::WAKE_PORT_B_BIT) |
    (16'(port_a_wake_flag) << wsrg_pkg::WAKE_PORT_A_BIT) |
    (16'(watchdog_wake_flag) << wsrg_pkg::WAKE_WATCHDOG_BIT) |
    (16'(low_voltage_wake_flag) << wsrg_pkg::WAKE_LOW_VOLTAGE_BIT);

  // Bit drops when the source flag drops or on sys_rst; unused positions stay 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_source_status <= wsrg_pkg::WAKE_RESET;
    end else begin
      wake_source_status <= next_wake_status;
    end
  end

endmodule

// File: core/wsrg_reset_gate.sv
// Reset gate: masks each reset source event with its enable bit
`timescale 1ns/1ps
module wsrg_reset_gate (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] reset_events,
  input wire logic [6:0] reset_source_enable,
  output logic [6:0] reset_forward,
  output logic reset_request
);

  wire [6:0] gated;
  assign gated = reset_events & reset_source_enable;

  // One flop per source, so each forwarded line is glitch free
  genvar i;
  generate
    for (i = 0; i < wsrg_pkg::RST_SOURCES; i++) begin : g_src
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          reset_forward[i] <= 1'b0;
        end else begin
          reset_forward[i] <= gated[i];
        end
      end
    end
  endgenerate

  // Single request to the reset generator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= |gated;
    end
  end

endmodule

// File: sim/wsrg_src_model.sv
// Peripheral event sources and reset events facing the wake/reset gate
`timescale 1ns/1ps
module wsrg_src_model (
  input wire logic clk,
  output logic [5:0] wake_flags,
  output logic [6:0] reset_events
);
  // ----------------------------------------------------------------
  // Flag levels: index 5..0 is port d, c, b, a, watchdog, low voltage
  // ----------------------------------------------------------------
  initial begin
    wake_flags = 6'h00;
    reset_events = 7'h00;
  end

  // A peripheral raises its interrupt flag right after an edge; any
  // source index passed in is raised here, with no wake enable checked
  task automatic raise_wake(input int idx);
    @(posedge clk);
    wake_flags[idx] <= 1'b1;
  endtask

  // Software clears a port flag in the pin controller
  // Software clears the watchdog overflow flag in the watchdog
  // The detector drops its flag once the supply recovers
  task automatic clear_wake(input int idx);
    @(posedge clk);
    wake_flags[idx] <= 1'b0;
  endtask

  // Reset event levels, held until changed again
  task automatic set_events(input logic [6:0] v);
    @(posedge clk);
    reset_events <= v;
  endtask
endmodule

// File: sim/tb.sv
// Testbench for the wake status view and reset source gate
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, cyc, stb, we, ack, irq, rreq;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [15:0] wss;
  logic [6:0] fwd, ev;
  logic [5:0] wf;
  int n_fail, compares;
  int pos[6] = '{0, 1, 8, 9, 10, 11};

  wsrg_src_model src (.clk(clk), .wake_flags(wf), .reset_events(ev));

  wsrg_top DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_d_wake_flag(wf[5]), .port_c_wake_flag(wf[4]),
    .port_b_wake_flag(wf[3]), .port_a_wake_flag(wf[2]), .watchdog_wake_flag(wf[1]),
    .low_voltage_wake_flag(wf[0]), .pin_reset_event(ev[6]),
    .cpu_request_reset_event(ev[5]), .software_reset_event(ev[4]),
    .watchdog_reset_event(ev[3]), .main_clock_fail_event(ev[2]),
    .ext_osc_fail_event(ev[1]), .low_voltage_reset_event(ev[0]),
    .wake_source_status(wss), .reset_forward(fwd), .reset_request(rreq), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; hold until ack is sampled, no latency assumed
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t no ack", $time);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Write with chosen byte lanes, so lane decoding is exercised too
  task automatic wr_sel(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wr_sel(a, d, 4'hf);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(q, exp, what);
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic close_out;
    $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this span is generous
  initial begin
    #200000;
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    close_out;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(wsrg_pkg::RSE_ADDR, 32'h0000_0049, "enable reset");
    rd(wsrg_pkg::WAKE_STATUS_ADDR, 32'h0000_0000, "wake reset");
    chk({23'h00_0000, irq, rreq, fwd}, 32'h0000_0000, "outputs idle");
    $display("test reset values done");
    // Each wake source in turn: set, ignore write, clear at source
    for (int i = 0; i < 6; i++) begin
      src.raise_wake(i);
      wait_n(3);
      chk({16'h0000, wss}, 32'h0000_0001 << pos[i], "wake port");
      wr(wsrg_pkg::WAKE_STATUS_ADDR, 32'h0000_ffff);
      rd(wsrg_pkg::WAKE_STATUS_ADDR, 32'h0000_0001 << pos[i], "wake reg");
      wait_n(4);
      chk({16'h0000, wss}, 32'h0000_0001 << pos[i], "wake held");
      src.clear_wake(i);
      wait_n(3);
      chk({16'h0000, wss}, 32'h0000_0000, "wake cleared");
    end
    $display("test wake status done");
    // All events active; one enable at a time must pass exactly one
    src.set_events(7'h7f);
    for (int i = 0; i < 7; i++) begin
      wr(wsrg_pkg::RSE_ADDR, 32'h0000_0001 << i);
      rd(wsrg_pkg::RSE_ADDR, 32'h0000_0001 << i, "enable rw");
      wait_n(2);
      chk({25'h000_0000, fwd}, 32'h0000_0001 << i, "forward");
      chk({31'h0000_0000, rreq}, 32'h0000_0001, "request");
    end
    wr(wsrg_pkg::RSE_ADDR, 32'h0000_0000);
    wait_n(2);
    chk({24'h00_0000, rreq, fwd}, 32'h0000_0000, "all masked");
    src.set_events(7'h00);
    // Enable register listens on byte lane 0 only
    wr_sel(wsrg_pkg::RSE_ADDR, 32'h0000_007f, 4'he);
    rd(wsrg_pkg::RSE_ADDR, 32'h0000_0000, "enable lane off");
    wr_sel(wsrg_pkg::RSE_ADDR, 32'h0000_007f, 4'h1);
    rd(wsrg_pkg::RSE_ADDR, 32'h0000_007f, "enable lane on");
    $display("test reset gate done");
    // Sticky status holds every wake edge and the request edge
    rd(wsrg_pkg::IRQ_STATUS_ADDR, 32'h0000_8f03, "irq sticky");
    rd(wsrg_pkg::IRQ_STATUS_ADDR, 32'h0000_0000, "irq read clear");
    wr_sel(wsrg_pkg::IRQ_MASK_ADDR, 32'h0000_0103, 4'h2);
    wr_sel(wsrg_pkg::IRQ_MASK_ADDR, 32'h0000_ffff, 4'hc);
    rd(wsrg_pkg::IRQ_MASK_ADDR, 32'h0000_0100, "mask lanes");
    src.raise_wake(2);
    wait_n(4);
    chk({31'h0000_0000, irq}, 32'h0000_0001, "irq raised");
    rd(wsrg_pkg::IRQ_STATUS_ADDR, 32'h0000_0100, "irq cause");
    wait_n(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
    src.clear_wake(2);
    wr(wsrg_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
    src.raise_wake(3);
    wait_n(4);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
    src.clear_wake(3);
    // Unmapped place: write lost, reads zero
    wr(32'h4000_0200, 32'hffff_ffff);
    rd(32'h4000_0200, 32'h0000_0000, "unmapped");
    $display("test interrupt and unmapped done");
    close_out;
  end
endmodule
